// [dbt_pkg.sv]
// Shared constants and types for the debug breakpoint trap unit.
package dbt_pkg;

  // ----------------------------------------------------------------
  // Register map (index on the register port).
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_BP0     = 3'h0;  // Address registers 0..3 at 0..3.
  localparam logic [2:0] OFS_STATUS  = 3'h4;  // Debug status register.
  localparam logic [2:0] OFS_CONTROL = 3'h5;  // Debug control register.
  localparam logic [2:0] OFS_CR4     = 3'h6;  // Control register four image.
  localparam logic [2:0] OFS_FLAGS   = 3'h7;  // Flags register image.

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int NUM_BP   = 4;   // Breakpoint address registers.
  localparam int GD_BIT   = 13;  // General-detect enable in control.
  localparam int RW_LSB   = 16;  // Access type of bp n at RW_LSB+4n.
  localparam int LEN_LSB  = 18;  // Match length of bp n at LEN_LSB+4n.
  localparam int BD_BIT   = 13;  // General-detect hit in status.
  localparam int BT_BIT   = 15;  // Task breakpoint flag in status.
  localparam int DE_BIT   = 3;   // Debug extension enable in cr4.
  localparam int RF_BIT   = 16;  // Resume flag in flags image.
  localparam logic [63:0] LOCAL_MASK  = 64'h0000_0000_0000_0055;
  localparam logic [63:0] CONTROL_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STATUS_RST  = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  DB_VECTOR   = 8'h01;

  // Access type codes.
  typedef enum logic [1:0] {
    ACC_INSTR = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_IO    = 2'b10,
    ACC_RW    = 2'b11
  } dbt_acc_t;

  // Match length codes.
  typedef enum logic [1:0] {
    LEN_1 = 2'b00,
    LEN_2 = 2'b01,
    LEN_8 = 2'b10,
    LEN_4 = 2'b11
  } dbt_len_t;

endpackage

// [dbt_trap_unit.sv]
// Debug breakpoint trap unit: address compare, status, exception request.
//
// Notes on behaviour
// RL1: Every debug exception uses vector one.
// RL2: Instruction and general-detect trap before; others after.
// RL3: Repeated operations may trap between iterations.
// RL4: Post-instruction conditions outrank instruction matches.
// RL5: Same instruction: instruction match first, data after.
// RL6: Armed only when local or global enable set.
// RL7: Type 00 compares next instruction address only.
// RL8: Instruction match sets hit, returns matched address.
// RL9: Resume flag masks instruction matches for one instruction.
// RL10: Type 01 matches writes, 11 reads and writes.
// RL11: Length codes give one, two, four, eight bytes.
// RL12: Data match traps after access, returns next address.
// RL13: Unfinished repeated string returns its own address.
// RL14: Type 10 compares I/O ports when extensions enabled.
// RL15: I/O lengths select byte, word, doubleword.
// RL16: Port address zero-extended to 64 bits.
// RL17: Repeated port strings trap after each iteration.
// RL18: Trapped task switch raises exception, sets task flag.
// RL19: Task trap bit is never cleared here.
// RL20: General detect traps any debug register move.
// RL21: General detect clears enable, sets detect hit.
// RL22: General detect traps before the move executes.
// RL23: Length masks low address bits; overlap matches.
// RL24: Task switch clears local enables, never global.
// RL25: All registers compared in parallel, all hits set.
module dbt_trap_unit
  import dbt_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [63:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [63:0] reg_rdata_out,
  input  wire logic        instr_valid_in,
  input  wire logic [63:0] instr_addr_in,
  input  wire logic        instr_dr_move_in,
  input  wire logic        retire_in,
  input  wire logic [63:0] retire_addr_in,
  input  wire logic [63:0] retire_next_in,
  input  wire logic        rep_pending_in,
  input  wire logic        mem_valid_in,
  input  wire logic        mem_write_in,
  input  wire logic [63:0] mem_addr_in,
  input  wire logic [1:0]  mem_size_in,
  input  wire logic        io_valid_in,
  input  wire logic [15:0] io_port_in,
  input  wire logic [1:0]  io_size_in,
  input  wire logic        long_mode_in,
  input  wire logic        task_switch_in,
  input  wire logic        task_trap_in,
  input  wire logic [63:0] task_entry_in,
  output logic             exc_out,
  output logic      [7:0]  exc_vector_out,
  output logic             exc_before_out,
  output logic      [63:0] return_addr_out
);

  // ----------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;  // Two-stage release of the reset.
  logic       rst_n;     // Synchronised reset used everywhere else.

  // The reset asserts at once but leaves only after two edges.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [63:0] bp_address_reg [NUM_BP];  // Breakpoint addresses.
  logic [63:0] debug_control_reg;        // Enables, types, lengths.
  logic [63:0] debug_status_reg;         // Hit flags.
  logic        debug_ext_enable;         // Bit of control register four.
  logic        resume_flag;              // Bit of the flags register.

  // ----------------------------------------------------------------
  // Range compare helpers.
  // ----------------------------------------------------------------
  // Byte span of a length code; the eight-byte code only counts in long
  // mode, otherwise it is treated as one byte.
  function automatic logic [63:0] span_of(input logic [1:0] len, input logic lm);
    // Codes outside the table fall back to one byte.
    case (dbt_len_t'(len))
      LEN_2:   span_of = 64'h2; // RL11
      LEN_4:   span_of = 64'h4; // RL11
      LEN_8:   span_of = lm ? 64'h8 : 64'h1; // RL11
      default: span_of = 64'h1; // RL11
    endcase
  endfunction

  // True when any byte of the access falls in the masked breakpoint range.
  function automatic logic overlap(input logic [63:0] a, input logic [1:0] asz,
                                   input logic [63:0] bp, input logic [1:0] len,
                                   input logic lm);
    logic [63:0] sp;
    logic [63:0] lo;
    logic [63:0] hi;
    logic [63:0] ahi;

    sp  = span_of(len, lm);
    lo  = bp & ~(sp - 64'h1); // RL23
    hi  = lo + sp - 64'h1;
    ahi = a + (64'h1 << asz) - 64'h1;
    overlap = (a <= hi) && (ahi >= lo); // RL23
  endfunction

  // ----------------------------------------------------------------
  // Per-register match logic.
  // ----------------------------------------------------------------
  logic [NUM_BP-1:0] instr_hit;  // Instruction address matches.
  logic [NUM_BP-1:0] data_hit;   // Memory access matches.
  logic [NUM_BP-1:0] io_hit;     // Port access matches.
  logic [63:0]       io_addr;    // Port number widened for compare.

  assign io_addr = {48'h0, io_port_in};           // RL16

  // All four comparators run side by side every cycle.
  generate
    for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
      logic       armed;
      logic [1:0] acc;
      logic [1:0] len;
      assign armed = debug_control_reg[2*i] | debug_control_reg[2*i+1];  // RL6
      assign acc   = debug_control_reg[RW_LSB+4*i +: 2];
      assign len   = debug_control_reg[LEN_LSB+4*i +: 2];

      // Instruction compare is exact; length must be programmed to one byte.
      assign instr_hit[i] = armed && (acc == ACC_INSTR) // RL7
                            && (instr_addr_in == bp_address_reg[i]);

      // Write-only or read-write data compare.
      assign data_hit[i] = armed && mem_valid_in
                           && ((acc == ACC_RW) || ((acc == ACC_WRITE) && mem_write_in)) // RL10
                           && overlap(mem_addr_in, mem_size_in, bp_address_reg[i],
                                      len, long_mode_in); // RL23

      // Port compare only exists with the debug extensions on.
      // Port lengths are byte spans, as for data outside long mode.
      assign io_hit[i] = armed && io_valid_in && debug_ext_enable // RL14
                         && (acc == ACC_IO)
                         && overlap(io_addr, io_size_in, bp_address_reg[i],
                                    len, 1'b0); // RL15
    end
  endgenerate

  // ----------------------------------------------------------------
  // Exception decision.
  // ----------------------------------------------------------------
  logic [NUM_BP-1:0] post_hit;   // Hits reported after the instruction.
  logic              task_fire;  // Trapped task switch.
  logic              post_fire;  // After-instruction exception this cycle.
  logic              gd_fire;    // General-detect exception.
  logic              im_fire;    // Instruction-match exception.
  logic              pre_fire;   // Before-instruction exception.

  assign post_hit  = retire_in ? (data_hit | io_hit) : '0;  // RL25
  assign task_fire = task_switch_in && task_trap_in; // RL18

  // Each retire may be one iteration of a repeated operation, so a hit
  // can be reported between iterations.
  assign post_fire = (|post_hit) || task_fire; // RL3

  // Pending after-instruction work wins; the dropped instruction check is
  // made again when the core presents the instruction after the handler.
  assign gd_fire   = instr_valid_in && instr_dr_move_in
                     && debug_control_reg[GD_BIT] && !post_fire; // RL20

  // The resume flag hides matches only; general detect still acts.
  assign im_fire   = instr_valid_in && !resume_flag
                     && (|instr_hit) && !post_fire; // RL4

  assign pre_fire  = gd_fire || im_fire; // RL2

  // ----------------------------------------------------------------
  // Address registers and control register four.
  // ----------------------------------------------------------------
  // Software writes; the trapped move never reaches here because the core
  // holds it back while the exception is taken first.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_BP; k++) begin
        bp_address_reg[k] <= 64'h0;
      end
      debug_ext_enable <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in < OFS_STATUS) begin
        bp_address_reg[reg_addr_in[1:0]] <= reg_wdata_in;
      end

      // Only the extension bit of the image is kept.
      if (reg_addr_in == OFS_CR4) begin
        debug_ext_enable <= reg_wdata_in[DE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register.
  // ----------------------------------------------------------------
  // Hardware clears take effect on top of a same-cycle software write.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      debug_control_reg <= CONTROL_RST;
    end else begin
      logic [63:0] next_ctl;
      next_ctl = (reg_wr_in && reg_addr_in == OFS_CONTROL) ? reg_wdata_in
                                                           : debug_control_reg;

      // Locals belong to the old task; globals survive.
      if (task_switch_in) begin
        next_ctl = next_ctl & ~LOCAL_MASK; // RL24
      end

      if (gd_fire) begin
        next_ctl[GD_BIT] = 1'b0; // RL21
      end
      debug_control_reg <= next_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Status register.
  // ----------------------------------------------------------------
  // Software may clear flags by writing; a hit in the same cycle wins.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      debug_status_reg <= STATUS_RST;
    end else begin
      logic [63:0] next_sts;
      next_sts = (reg_wr_in && reg_addr_in == OFS_STATUS) ? reg_wdata_in
                                                          : debug_status_reg;

      if (post_fire) begin
        next_sts[NUM_BP-1:0] = next_sts[NUM_BP-1:0] | post_hit; // RL12
        next_sts[BT_BIT]     = next_sts[BT_BIT] | task_fire; // RL18
      end

      if (im_fire) begin
        next_sts[NUM_BP-1:0] = next_sts[NUM_BP-1:0] | instr_hit; // RL8
      end

      if (gd_fire) begin
        next_sts[BD_BIT] = 1'b1; // RL21
      end
      debug_status_reg <= next_sts;
    end
  end

  // ----------------------------------------------------------------
  // Resume flag.
  // ----------------------------------------------------------------
  // Cleared when an instruction retires; a software set in that cycle wins.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      resume_flag <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == OFS_FLAGS) begin
      resume_flag <= reg_wdata_in[RF_BIT];
    end else if (retire_in) begin
      // Any retire counts as the one instruction the flag covers.
      resume_flag <= 1'b0; // RL9
    end
  end

  // ----------------------------------------------------------------
  // Exception request outputs.
  // ----------------------------------------------------------------
  // The task trap bit lives in memory and is left for software to clear.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      exc_out         <= 1'b0;
      exc_vector_out  <= 8'h00;
      exc_before_out  <= 1'b0;
      return_addr_out <= 64'h0;
    end else begin
      // One-cycle pulse; the core takes it at the next edge.
      exc_out        <= post_fire || pre_fire;
      exc_vector_out <= DB_VECTOR; // RL1
      exc_before_out <= pre_fire; // RL22

      // The new task's first instruction is where the handler returns.
      if (task_fire) begin
        return_addr_out <= task_entry_in; // RL19
      end else if (post_fire && rep_pending_in) begin
        return_addr_out <= retire_addr_in; // RL13 RL17
      end else if (post_fire) begin
        return_addr_out <= retire_next_in; // RL12
      end else if (pre_fire) begin
        return_addr_out <= instr_addr_in; // RL8 RL5
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port.
  // ----------------------------------------------------------------
  // Data stand in the cycle after the read strobe and only there.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 64'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_STATUS:  reg_rdata_out <= debug_status_reg;
        OFS_CONTROL: reg_rdata_out <= debug_control_reg;
        OFS_CR4:     reg_rdata_out <= {60'h0, debug_ext_enable, 3'h0};
        OFS_FLAGS:   reg_rdata_out <= {47'h0, resume_flag, 16'h0};
        default:     reg_rdata_out <= bp_address_reg[reg_addr_in[1:0]];
      endcase
    end else begin
      reg_rdata_out <= 64'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  a_vector_one: assert property (exc_out |-> exc_vector_out == 8'h01)  // RL1
    else $error("debug exception not on vector one");

  a_gd_before: assert property (gd_fire |=> exc_out && exc_before_out)  // RL22
    else $error("general detect not raised before instruction");

  a_post_after: assert property (post_fire |=> exc_out && !exc_before_out)  // RL2
    else $error("post condition not raised after instruction");

  a_post_priority: assert property ((post_fire && instr_valid_in) |=> !exc_before_out)  // RL4
    else $error("instruction match beat post condition");

  a_rf_masks: assert property ((resume_flag && instr_valid_in && !instr_dr_move_in && !post_fire)
                               |=> !exc_out)  // RL9
    else $error("instruction match taken while resume flag set");

  a_rf_clears: assert property ((retire_in && !(reg_wr_in && reg_addr_in == OFS_FLAGS))
                                |=> !resume_flag)  // RL9
    else $error("resume flag not cleared on retire");

  a_imatch_ret: assert property (im_fire |=> return_addr_out == $past(instr_addr_in))  // RL8
    else $error("instruction match return address wrong");

  a_gd_clears: assert property (gd_fire |=> !debug_control_reg[GD_BIT] && debug_status_reg[BD_BIT])  // RL21
    else $error("general detect bits not updated");

  a_task_local: assert property (task_switch_in |=> (debug_control_reg & LOCAL_MASK) == 64'h0)  // RL24
    else $error("local enables survive task switch");

  a_rep_return: assert property ((post_fire && rep_pending_in && !task_fire)
                                 |=> return_addr_out == $past(retire_addr_in))  // RL13
    else $error("repeat return address wrong");

  a_io_gated: assert property (!debug_ext_enable |-> io_hit == '0)  // RL14
    else $error("port match without extensions");

  c_instr_match: cover property (im_fire);
  c_gen_detect: cover property (gd_fire);
  c_rep_data: cover property (post_fire && rep_pending_in);
  c_task_trap: cover property (task_fire);
  c_multi_hit: cover property ($countones(post_hit) > 1);

endmodule

// [dbt_trap_unit_tb.sv]
// Self-checking testbench for the debug breakpoint trap unit.
module dbt_trap_unit_tb
  import dbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Design ports; every input has a value at time zero.
  // ----------------------------------------------------------------
  logic        clock_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic [2:0]  reg_addr_in = 3'h0;
  logic [63:0] reg_wdata_in = 64'h0;
  logic        reg_wr_in = 1'h0;
  logic        reg_rd_in = 1'h0;
  logic [63:0] reg_rdata_out;
  logic        instr_valid_in = 1'h0;
  logic [63:0] instr_addr_in = 64'h0;
  logic        instr_dr_move_in = 1'h0;
  logic        retire_in = 1'h0;
  logic [63:0] retire_addr_in = 64'h0;
  logic [63:0] retire_next_in = 64'h0;
  logic        rep_pending_in = 1'h0;
  logic        mem_valid_in = 1'h0;
  logic        mem_write_in = 1'h0;
  logic [63:0] mem_addr_in = 64'h0;
  logic [1:0]  mem_size_in = 2'h0;
  logic        io_valid_in = 1'h0;
  logic [15:0] io_port_in = 16'h0;
  logic [1:0]  io_size_in = 2'h0;
  logic        long_mode_in = 1'h1;
  logic        task_switch_in = 1'h0;
  logic        task_trap_in = 1'h0;
  logic [63:0] task_entry_in = 64'h0;
  logic        exc_out;
  logic [7:0]  exc_vector_out;
  logic        exc_before_out;
  logic [63:0] return_addr_out;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;

  // One data or port case: breakpoint setup, the access, and whether it traps.
  typedef struct {
    logic [63:0] bp;
    logic [1:0]  acc;
    logic [1:0]  len;
    logic        wr;
    logic        io;
    logic [63:0] addr;
    logic [1:0]  size;
    logic        hit;
  } dbt_row_t;

  // Ranges straddle the breakpoint on both sides to catch off-by-one masks.
  dbt_row_t rows [15] = '{
    '{64'hf000,2'h3,2'h0,1'h0,1'h0,64'heffb,2'h3,1'h1},
    '{64'hf000,2'h3,2'h0,1'h0,1'h0,64'heffe,2'h1,1'h0},
    '{64'hf000,2'h3,2'h0,1'h0,1'h0,64'heffe,2'h2,1'h1},
    '{64'hf000,2'h3,2'h0,1'h0,1'h0,64'hf001,2'h1,1'h0},
    '{64'hf004,2'h3,2'h3,1'h0,1'h0,64'hf005,2'h2,1'h1},
    '{64'hf004,2'h3,2'h3,1'h0,1'h0,64'hf000,2'h0,1'h0},
    '{64'hf005,2'h3,2'h2,1'h0,1'h0,64'heffb,2'h3,1'h1},
    '{64'hf005,2'h3,2'h2,1'h0,1'h0,64'hf000,2'h0,1'h1},
    '{64'hf005,2'h3,2'h2,1'h0,1'h0,64'heffe,2'h1,1'h0},
    '{64'hf000,2'h1,2'h0,1'h0,1'h0,64'hf000,2'h0,1'h0},
    '{64'hf000,2'h1,2'h0,1'h1,1'h0,64'hf000,2'h0,1'h1},
    '{64'h0060,2'h2,2'h0,1'h0,1'h1,64'h0060,2'h0,1'h1},
    '{64'h0060,2'h2,2'h0,1'h0,1'h1,64'h0061,2'h0,1'h0},
    '{64'h0063,2'h2,2'h1,1'h0,1'h1,64'h0062,2'h0,1'h1},
    '{64'h10060,2'h2,2'h0,1'h0,1'h1,64'h0060,2'h0,1'h0}};

  dbt_trap_unit dut_u (.clock_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .instr_valid_in, .instr_addr_in, .instr_dr_move_in, .retire_in, .retire_addr_in,
    .retire_next_in, .rep_pending_in, .mem_valid_in, .mem_write_in, .mem_addr_in, .mem_size_in,
    .io_valid_in, .io_port_in, .io_size_in, .long_mode_in, .task_switch_in, .task_trap_in,
    .task_entry_in, .exc_out, .exc_vector_out, .exc_before_out, .return_addr_out);

  // ----------------------------------------------------------------
  // Clock and hang guard.
  // ----------------------------------------------------------------
  // Half period of 50 ns gives the 10 MHz core clock.
  always #50 clock_in = ~clock_in;

  // A run takes under a thousand cycles; 5000 means a hang.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Reports a seen value that differs from the expected.
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic reg_wr(input logic [2:0] a, input logic [63:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'h1;
    @(posedge clock_in);
    reg_wr_in <= 1'h0;
  endtask

  // One-cycle read; data checked in their one cycle.
  task automatic reg_rd(input logic [2:0] a, input logic [63:0] exp, input string nm);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'h1;
    @(posedge clock_in);
    reg_rd_in <= 1'h0;
    #1;
    check(nm, reg_rdata_out, exp);
  endtask

  // Checks status, then clears it.
  task automatic status_is(input logic [63:0] exp);
    reg_rd(OFS_STATUS, exp, "status");
    reg_wr(OFS_STATUS, 64'h0);
  endtask

  // Control word for one breakpoint register.
  function automatic logic [63:0] ctl(input int n, input logic [1:0] en, input logic [1:0] acc,
                                      input logic [1:0] len);
    return (64'(en) << (2 * n)) | (64'(acc) << (RW_LSB + 4 * n)) | (64'(len) << (LEN_LSB + 4 * n));
  endfunction

  // Presents an instruction after a rising edge.
  task automatic instr(input logic [63:0] a, input logic mv);
    instr_valid_in   <= 1'h1;
    instr_addr_in    <= a;
    instr_dr_move_in <= mv;
  endtask

  // Retires an instruction; ports reuse address and size.
  task automatic retire(input logic [63:0] ra, input logic [63:0] nx, input logic loop_prefix, input logic memv,
                        input logic wr, input logic [63:0] ma, input logic [1:0] ms, input logic iov);
    retire_in      <= 1'h1;
    retire_addr_in <= ra;
    retire_next_in <= nx;
    rep_pending_in <= loop_prefix;
    mem_valid_in   <= memv;
    mem_write_in   <= wr;
    mem_addr_in    <= ma;
    mem_size_in    <= ms;
    io_valid_in    <= iov;
    io_port_in     <= ma[15:0];
    io_size_in     <= ms;
  endtask

  // Drops the event pulses, then lets outputs settle.
  task automatic settle();
    @(posedge clock_in);
    instr_valid_in <= 1'h0;
    retire_in      <= 1'h0;
    task_switch_in <= 1'h0;
    #1;
  endtask

  // Exception outputs one cycle after the triggering edge.
  task automatic check_exc(input logic e, input logic b, input logic [63:0] r);
    check("exc", {63'h0, exc_out}, {63'h0, e});
    if (e) begin
      check("before", {63'h0, exc_before_out}, {63'h0, b});
      check("return", return_addr_out, r);
      check("vector", {56'h0, exc_vector_out}, 64'h1);
    end
  endtask

  // Ten cycles of reset, then the synchroniser's delay.
  task automatic do_reset();
    rst_n_in <= 1'h0;
    repeat (10) @(posedge clock_in);
    check("vector in reset", {56'h0, exc_vector_out}, 64'h0);
    rst_n_in <= 1'h1;
    repeat (3) @(posedge clock_in);
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    reg_wr(OFS_CR4, 64'h8);
    // Table cases, register zero, global enable.
    foreach (rows[i]) begin
      reg_wr(OFS_BP0, rows[i].bp);
      reg_wr(OFS_CONTROL, ctl(0, 2'h2, rows[i].acc, rows[i].len));
      @(posedge clock_in);
      retire(64'h4000, 64'h4004, 1'h0, !rows[i].io, rows[i].wr, rows[i].addr, rows[i].size, rows[i].io);
      settle();
      check_exc(rows[i].hit, 1'h0, 64'h4004);
      status_is({63'h0, rows[i].hit});
    end
    // Port type is inert while debug extensions are off.
    reg_wr(OFS_CR4, 64'h0);
    reg_wr(OFS_BP0, 64'h60);
    reg_wr(OFS_CONTROL, ctl(0, 2'h2, ACC_IO, LEN_1));
    @(posedge clock_in);
    retire(64'h4000, 64'h4004, 1'h0, 1'h0, 1'h0, 64'h60, 2'h0, 1'h1);
    settle();
    check_exc(1'h0, 1'h0, 64'h0);
    reg_wr(OFS_CR4, 64'h8);
    // Repeated port string traps each iteration, returns to itself.
    repeat (2) begin
      @(posedge clock_in);
      retire(64'h2000, 64'h2002, 1'h1, 1'h0, 1'h0, 64'h60, 2'h0, 1'h1);
      settle();
      check_exc(1'h1, 1'h0, 64'h2000);
    end
    // Instruction match with local enable only; then the same with no enable.
    reg_wr(OFS_BP0, 64'h1000);
    reg_wr(OFS_CONTROL, ctl(0, 2'h1, ACC_INSTR, LEN_1));
    @(posedge clock_in);
    instr(64'h1000, 1'h0);
    settle();
    check_exc(1'h1, 1'h1, 64'h1000);
    status_is(64'h1);
    reg_wr(OFS_CONTROL, ctl(0, 2'h0, ACC_INSTR, LEN_1));
    @(posedge clock_in);
    instr(64'h1000, 1'h0);
    settle();
    check_exc(1'h0, 1'h0, 64'h0);
    // Resume flag hides one instruction match, then clears on retire.
    reg_wr(OFS_CONTROL, ctl(0, 2'h1, ACC_INSTR, LEN_1) | ctl(1, 2'h2, ACC_RW, LEN_1));
    reg_wr(3'h1, 64'h5000);
    reg_wr(OFS_FLAGS, 64'h1_0000);
    @(posedge clock_in);
    instr(64'h1000, 1'h0);
    settle();
    check_exc(1'h0, 1'h0, 64'h0);
    @(posedge clock_in);
    retire(64'h1000, 64'h1003, 1'h0, 1'h0, 1'h0, 64'h0, 2'h0, 1'h0);
    settle();
    reg_rd(OFS_FLAGS, 64'h0, "flags");
    // One instruction hits both: instruction match first.
    @(posedge clock_in);
    instr(64'h1000, 1'h0);
    settle();
    check_exc(1'h1, 1'h1, 64'h1000);
    status_is(64'h1);
    @(posedge clock_in);
    retire(64'h1000, 64'h1003, 1'h0, 1'h1, 1'h0, 64'h5000, 2'h0, 1'h0);
    settle();
    check_exc(1'h1, 1'h0, 64'h1003);
    status_is(64'h2);
    // Pending data match beats the next instruction match.
    @(posedge clock_in);
    instr(64'h1000, 1'h0);
    retire(64'h0ffc, 64'h1000, 1'h0, 1'h1, 1'h1, 64'h5000, 2'h0, 1'h0);
    settle();
    check_exc(1'h1, 1'h0, 64'h1000);
    status_is(64'h2);
    // Two registers hit by one access: both flags in one exception.
    reg_wr(OFS_BP0, 64'h5000);
    reg_wr(3'h1, 64'h5002);
    reg_wr(OFS_CONTROL, ctl(0, 2'h2, ACC_RW, LEN_1) | ctl(1, 2'h2, ACC_RW, LEN_1));
    @(posedge clock_in);
    retire(64'h2000, 64'h2002, 1'h1, 1'h1, 1'h0, 64'h5000, 2'h2, 1'h0);
    settle();
    check_exc(1'h1, 1'h0, 64'h2000);
    status_is(64'h3);
    // Trapped task switch: task flag, entry address, local enables dropped.
    reg_wr(OFS_CONTROL, 64'h9);
    @(posedge clock_in);
    task_switch_in <= 1'h1;
    task_trap_in   <= 1'h1;
    task_entry_in  <= 64'h3000;
    settle();
    check_exc(1'h1, 1'h0, 64'h3000);
    status_is(64'h8000);
    reg_rd(OFS_CONTROL, 64'h8, "control");
    // General detect: traps first, clears enable, sets flag.
    reg_wr(OFS_CONTROL, 64'h1 << GD_BIT);
    @(posedge clock_in);
    instr(64'h6000, 1'h1);
    settle();
    instr_dr_move_in <= 1'h0;
    check_exc(1'h1, 1'h1, 64'h6000);
    status_is(64'h1 << BD_BIT);
    reg_rd(OFS_CONTROL, 64'h0, "control");
    reg_rd(OFS_BP0, 64'h5000, "bp0");
    // Mid-run reset restores reset values.
    do_reset();
    reg_rd(OFS_STATUS, STATUS_RST, "status");
    reg_rd(OFS_CONTROL, CONTROL_RST, "control");
    finish_test();
  end
endmodule
